/* File: adc_seq_consts.svh */
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH
// ***********************************
// Register offsets and field layout
// ***********************************
`define CCO_OFFSET      8'h04
`define STAT_OFFSET     8'h00
`define CCO_RESET       32'h0000_0000
`define CCO_WMASK       32'h00CF_FFFF
`define CCO_WMASK_SLAVE 32'h00C0_FFFF
`define BIT_WREG        23
`define BIT_WINJ        22
`define PMODE_HI        19
`define PMODE_LO        16
`define CNT_HI          15
`define CNT_LO          13
`define BIT_IBURST      12
`define BIT_RBURST      11
`define BIT_AUTO        10
`define BIT_WSGL        9
`define BIT_SCAN        8
`define BIT_IIE         7
`define BIT_WIE         6
`define BIT_CIE         5
`define WCH_HI          4
`define WCH_LO          0
`define ST_WATCH        0
`define ST_DONE         1
`define ST_IDONE        2
`define WCH_MAX         5'h11
`endif

/* File: adc_seq_pkg.sv */
`default_nettype none
package adc_seq_pkg;
	// Pair operating modes
	typedef enum logic [3:0] {
		PM_INDEP      = 4'h0,
		PM_REG_INJ    = 4'h1,
		PM_REG_ALT    = 4'h2,
		PM_INJ_FAST   = 4'h3,
		PM_INJ_SLOW   = 4'h4,
		PM_INJ_ONLY   = 4'h5,
		PM_REG_ONLY   = 4'h6,
		PM_FAST_ONLY  = 4'h7,
		PM_SLOW_ONLY  = 4'h8,
		PM_ALT_ONLY   = 4'h9
	} pair_mode_t;
	// Sequencer states
	typedef enum logic [1:0] {S_IDLE, S_REG, S_INJ} seq_state_t;
endpackage
`default_nettype wire

/* File: adc_sequencer_control.sv */
// Operation
// - Regular watchdog checks only when bit 23 set
// - Injected watchdog checks only when bit 22 set
// - Pair mode codes zero to two decoded
// - Pair mode codes three to five decoded
// - Pair mode codes six to nine; rest unused
// - Pair mode exists only on master
// - Config change in pair mode restarts conversion
// - Regular burst converts count field plus one channels; injected burst converts one
// - Bit 12 makes injected group burst
// - Bit 11 makes regular group burst
// - Bit 10 chains injected after regular
// - Bit 9 limits watchdog to one channel
// - Scan bit converts whole sequence
// - Scan raises done only after last channel or a watchdog abort
// - Injected done flag raises interrupt if enabled
// - Watchdog flag raises interrupt if enabled
// - Watchdog aborts scan only when enabled
// - Done flag raises interrupt if enabled
// - Watch channel field selects channels 0..17
// - Channels 16, 17 internal or grounded
// - Done flag set per channel without scan, cleared by software/read
// - Watchdog flag set on crossing, software clears
`include "adc_seq_consts.svh"
`default_nettype none
module adc_sequencer_control
	import adc_seq_pkg::*;
#(
	parameter bit IS_MASTER = 1'b1
) (
	input  wire logic        core_clk_i,     // Converter clock
	input  wire logic        nrst_i,         // Async reset, active low
	input  wire logic [7:0]  addr_i,         // Register byte address
	input  wire logic [31:0] wdata_i,        // Write data
	input  wire logic        wr_i,           // Write strobe
	input  wire logic        rd_i,           // Read strobe
	output logic      [31:0] rdata_o,        // Read data, one cycle later
	input  wire logic        data_read_i,    // Data register read pulse
	input  wire logic        reg_trig_i,     // Regular group trigger
	input  wire logic        inj_trig_i,     // Injected group trigger
	input  wire logic [3:0]  reg_len_i,      // Regular sequence length minus one
	input  wire logic [1:0]  inj_len_i,      // Injected sequence length minus one
	input  wire logic        conv_done_i,    // One channel conversion finished
	input  wire logic [4:0]  conv_ch_i,      // Channel just converted
	input  wire logic        out_of_range_i, // Result outside thresholds
	input  wire logic        cfg_change_i,   // Channel configuration changed
	output logic             conv_start_o,   // Start one channel conversion
	output logic      [4:0]  seq_pos_o,      // Position within the sequence
	output logic             seq_inj_o,      // Current group is injected
	output logic      [3:0]  pair_mode_o,    // Effective pair mode
	output logic             restart_o,      // Conversion restart pulse
	output logic             int_ch_en_o,    // Channels 16/17 internal sources
	output logic             irq_o           // Interrupt request
);
	// ***********************************
	// Register file
	// ***********************************
	logic [31:0] ctrl_ff;
	logic        done_ff;
	logic        idone_ff;
	logic        watch_ff;
	logic [31:0] wmask;
	logic        wr_ctrl;
	logic        wr_stat;

	// Reserved bits dropped on write; slave has no pair mode to hold
	assign wmask   = IS_MASTER ? `CCO_WMASK : `CCO_WMASK_SLAVE;
	assign wr_ctrl = wr_i && (addr_i == `CCO_OFFSET);
	assign wr_stat = wr_i && (addr_i == `STAT_OFFSET);

	// Control register; reserved bits never stored
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_ff <= `CCO_RESET;
		end else if (wr_ctrl) begin
			ctrl_ff <= wdata_i & wmask;
		end
	end

	// ***********************************
	// Control fields
	// ***********************************
	logic       watch_reg_enable;
	logic       watch_inj_enable;
	logic       injected_burst_enable;
	logic       regular_burst_enable;
	logic       auto_injected_after_regular;
	logic       watch_single_channel;
	logic       scan_enable;
	logic       injected_done_irq_enable;
	logic       watch_irq_enable;
	logic       conversion_done_irq_enable;
	logic [2:0] burst_channel_count;
	logic [4:0] watch_channel_select;
	logic [3:0] pair_mode_select;

	// Named views of the stored control bits
	assign watch_reg_enable            = ctrl_ff[`BIT_WREG];
	assign watch_inj_enable            = ctrl_ff[`BIT_WINJ];
	assign pair_mode_select            = ctrl_ff[`PMODE_HI:`PMODE_LO];
	assign burst_channel_count         = ctrl_ff[`CNT_HI:`CNT_LO];
	assign injected_burst_enable       = ctrl_ff[`BIT_IBURST];
	assign regular_burst_enable        = ctrl_ff[`BIT_RBURST];
	assign auto_injected_after_regular = ctrl_ff[`BIT_AUTO];
	assign watch_single_channel        = ctrl_ff[`BIT_WSGL];
	assign scan_enable                 = ctrl_ff[`BIT_SCAN];
	assign injected_done_irq_enable    = ctrl_ff[`BIT_IIE];
	assign watch_irq_enable            = ctrl_ff[`BIT_WIE];
	assign conversion_done_irq_enable  = ctrl_ff[`BIT_CIE];
	assign watch_channel_select        = ctrl_ff[`WCH_HI:`WCH_LO];

	// Pair mode decode; unused codes fall back to independent
	pair_mode_t mode_dec;
	always_comb begin
		unique case (pair_mode_select)
			4'h0: mode_dec = PM_INDEP;
			4'h1: mode_dec = PM_REG_INJ;
			4'h2: mode_dec = PM_REG_ALT;
			4'h3: mode_dec = PM_INJ_FAST;
			4'h4: mode_dec = PM_INJ_SLOW;
			4'h5: mode_dec = PM_INJ_ONLY;
			4'h6: mode_dec = PM_REG_ONLY;
			4'h7: mode_dec = PM_FAST_ONLY;
			4'h8: mode_dec = PM_SLOW_ONLY;
			4'h9: mode_dec = PM_ALT_ONLY;
			default: mode_dec = PM_INDEP;
		endcase
	end

	// ***********************************
	// Sequencer
	// ***********************************
	seq_state_t  state_ff;
	logic [3:0]  pos_ff;
	logic [3:0]  burst_ff;
	logic        busy_ff;
	logic        inj_pend_ff;
	logic        last_ch;
	logic        burst_end;
	logic        watch_hit;
	logic        abort_scan;
	logic        guard_ch;
	logic        grp_end;

	// Without scan every channel is the last of its group
	assign last_ch   = !scan_enable || (state_ff == S_INJ ? pos_ff[1:0] == inj_len_i
	                                                       : pos_ff == reg_len_i);
	// Regular burst ends after count plus one channels, injected burst after one
	assign burst_end = (state_ff == S_REG && regular_burst_enable && burst_ff == {1'b0, burst_channel_count})
	                || (state_ff == S_INJ && injected_burst_enable);
	// Reserved channel codes never match, so nothing is guarded then
	assign guard_ch  = !watch_single_channel || (conv_ch_i == watch_channel_select
	                                             && watch_channel_select <= `WCH_MAX);
	assign watch_hit = conv_done_i && out_of_range_i && guard_ch
	                && ((state_ff == S_REG && watch_reg_enable)
	                 || (state_ff == S_INJ && watch_inj_enable));
	assign abort_scan = watch_hit && watch_irq_enable && scan_enable;
	assign grp_end   = conv_done_i && (last_ch || abort_scan);

	// Group state
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_ff <= S_IDLE;
		end else if (restart_o) begin
			state_ff <= S_IDLE;
		end else begin
			unique case (state_ff)
				S_IDLE: begin
					if (inj_trig_i || inj_pend_ff) begin
						state_ff <= S_INJ;
					end else if (reg_trig_i) begin
						state_ff <= S_REG;
					end
				end
				S_REG: begin
					if (grp_end && auto_injected_after_regular && !abort_scan) begin
						state_ff <= S_INJ;
					end else if (grp_end || (conv_done_i && burst_end)) begin
						state_ff <= S_IDLE;
					end
				end
				S_INJ: begin
					if (conv_done_i && (grp_end || burst_end)) begin
						state_ff <= S_IDLE;
					end
				end
				default: begin
					// Unused code; fall back to idle
					state_ff <= S_IDLE;
				end
			endcase
		end
	end

	// Sequence position; regular position survives a burst pause with no injected group
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pos_ff <= 4'h0;
		end else if (restart_o) begin
			pos_ff <= 4'h0;
		end else if (state_ff == S_IDLE && (inj_trig_i || inj_pend_ff)) begin
			pos_ff <= 4'h0;
		end else if (conv_done_i && state_ff != S_IDLE) begin
			pos_ff <= grp_end ? 4'h0 : pos_ff + 4'h1;
		end
	end

	// Burst length counter, cleared by each trigger taken in idle
	// Four bits wide; compared with the 3-bit count zero-extended, at most seven
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			burst_ff <= 4'h0;
		end else if (restart_o || (state_ff == S_IDLE && (inj_trig_i || inj_pend_ff || reg_trig_i))) begin
			burst_ff <= 4'h0;
		end else if (conv_done_i && state_ff != S_IDLE) begin
			burst_ff <= burst_ff + 4'h1;
		end
	end

	// Injected trigger remembered while regular runs
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			inj_pend_ff <= 1'b0;
		end else if (inj_trig_i && state_ff == S_REG) begin
			inj_pend_ff <= 1'b1;
		end else if (state_ff == S_IDLE) begin
			inj_pend_ff <= 1'b0;
		end
	end

	// One start per channel; never two in a row
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			conv_start_o <= 1'b0;
		end else begin
			conv_start_o <= state_ff != S_IDLE && !busy_ff && !conv_start_o && !restart_o;
		end
	end

	// Busy from start until the converter reports done
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			busy_ff <= 1'b0;
		end else if (conv_start_o) begin
			busy_ff <= 1'b1;
		end else if (conv_done_i || restart_o) begin
			busy_ff <= 1'b0;
		end
	end

	// ***********************************
	// Status flags and interrupt
	// ***********************************
	logic set_done;
	logic set_idone;
	// In scan mode done flags wait for the group end
	assign set_done  = conv_done_i && state_ff != S_IDLE && (!scan_enable || grp_end);
	assign set_idone = conv_done_i && state_ff == S_INJ && grp_end;

	// Set wins over clear so no event is lost
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			done_ff <= 1'b0;
		end else if (set_done) begin
			done_ff <= 1'b1;
		end else if ((wr_stat && !wdata_i[`ST_DONE]) || data_read_i) begin
			done_ff <= 1'b0;
		end
	end

	// Injected done flag; a written zero clears it
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			idone_ff <= 1'b0;
		end else if (set_idone) begin
			idone_ff <= 1'b1;
		end else if (wr_stat && !wdata_i[`ST_IDONE]) begin
			idone_ff <= 1'b0;
		end
	end

	// Watch flag; only software clears it
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			watch_ff <= 1'b0;
		end else if (watch_hit) begin
			watch_ff <= 1'b1;
		end else if (wr_stat && !wdata_i[`ST_WATCH]) begin
			watch_ff <= 1'b0;
		end
	end

	// Registered interrupt; one cycle behind the flags
	// A flag and its enable must both be set
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= (done_ff && conversion_done_irq_enable)
			      || (idone_ff && injected_done_irq_enable)
			      || (watch_ff && watch_irq_enable);
		end
	end

	// ***********************************
	// Pair mode outputs and read port
	// ***********************************
	// Slave keeps pair mode at independent
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pair_mode_o <= 4'h0;
			restart_o   <= 1'b0;
			int_ch_en_o <= 1'b0;
			seq_pos_o   <= 5'h00;
			seq_inj_o   <= 1'b0;
		end else begin
			pair_mode_o <= IS_MASTER ? mode_dec : PM_INDEP;
			restart_o   <= cfg_change_i && mode_dec != PM_INDEP;
			int_ch_en_o <= IS_MASTER;
			seq_pos_o   <= {1'b0, pos_ff};
			seq_inj_o   <= state_ff == S_INJ;
		end
	end

	// Read data valid the cycle after the strobe; unmapped reads zero
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i && addr_i == `CCO_OFFSET) begin
			rdata_o <= ctrl_ff;
		end else if (rd_i && addr_i == `STAT_OFFSET) begin
			rdata_o <= {29'h0, idone_ff, done_ff, watch_ff};
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

/* File: adc_seq_checker.sv */
`include "adc_seq_consts.svh"
`default_nettype none
module adc_seq_checker (
	input wire logic        core_clk_i,     // Clock
	input wire logic        nrst_i,         // Async reset, active low
	input wire logic [7:0]  addr_i,         // Byte address
	input wire logic [31:0] wdata_i,        // Write data
	input wire logic        wr_i,           // Write strobe
	input wire logic        rd_i,           // Read strobe
	input wire logic [31:0] rdata_o,        // Read data
	input wire logic        conv_done_i,    // Channel finished
	input wire logic        out_of_range_i, // Threshold crossed
	input wire logic        cfg_change_i,   // Channel setup changed
	input wire logic        seq_inj_o,      // Injected group active
	input wire logic [3:0]  pair_mode_o,    // Effective pair mode
	input wire logic        restart_o,      // Restart pulse
	input wire logic        int_ch_en_o,    // Internal channels on
	input wire logic        irq_o           // Interrupt request
);
	logic [31:0] sh_ff;

	// ***************************************
	// Shadow of the control register
	// ***************************************
	// Kept from bus writes alone, so a stuck design register still shows up
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			sh_ff <= `CCO_RESET;
		else if (wr_i && addr_i == `CCO_OFFSET)
			sh_ff <= wdata_i & `CCO_WMASK;
	end

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	// ***************************************
	// Properties
	// ***************************************
	chk_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
		else $error("read data not zero outside read");
	chk_rd_ctrl: assert property (rd_i && addr_i == `CCO_OFFSET |=> rdata_o == $past(sh_ff))
		else $error("control readback wrong");
	chk_pair_mode: assert property ((wr_i && addr_i == `CCO_OFFSET) ##1 !wr_i |=>
		pair_mode_o == ($past(wdata_i[19:16], 2) <= 4'h9 ? $past(wdata_i[19:16], 2) : 4'h0))
		else $error("pair mode not applied");
	chk_irq_src: assert property (irq_o |-> $past(sh_ff[7] | sh_ff[6] | sh_ff[5]))
		else $error("interrupt with all enables off");
	chk_restart_src: assert property (restart_o |-> $past(cfg_change_i) &&
		$past(sh_ff[19:16]) inside {[4'h1:4'h9]}) else $error("restart without cause");
	chk_restart_go: assert property (cfg_change_i && sh_ff[19:16] inside {[4'h1:4'h9]} |=> restart_o)
		else $error("restart missing");
	chk_int_chan: assert property ($past(nrst_i) |-> int_ch_en_o)
		else $error("internal channels off on master");
	chk_watch_irq: assert property (conv_done_i && out_of_range_i && !seq_inj_o && !sh_ff[9] &&
		sh_ff[23] && sh_ff[6] |-> ##[1:3] irq_o) else $error("watch interrupt missing");
	chk_done_irq: assert property (conv_done_i && !sh_ff[8] && sh_ff[5] |-> ##[1:3] irq_o)
		else $error("done interrupt missing");
endmodule

bind adc_sequencer_control adc_seq_checker chk_i (.core_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
	.rd_i, .rdata_o, .conv_done_i, .out_of_range_i, .cfg_change_i, .seq_inj_o, .pair_mode_o,
	.restart_o, .int_ch_en_o, .irq_o);
`default_nettype wire

/* File: testbench.sv */
`include "adc_seq_consts.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        core_clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, data_read_i = 1'b0;
	logic        reg_trig_i = 1'b0, inj_trig_i = 1'b0, conv_done_i = 1'b0, out_of_range_i = 1'b0;
	logic        cfg_change_i = 1'b0, conv_start_o, seq_inj_o, restart_o, int_ch_en_o, irq_o;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0000_0000, rdata_o, rv;
	logic [4:0]  conv_ch_i = 5'h03, seq_pos_o;
	logic [3:0]  reg_len_i = 4'h0, pair_mode_o;
	logic [1:0]  inj_len_i = 2'h0;
	int          num_errors = 0, samples_checked = 0;

	adc_sequencer_control #(.IS_MASTER(1'b1)) dut (.core_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
		.rd_i, .rdata_o, .data_read_i, .reg_trig_i, .inj_trig_i, .reg_len_i, .inj_len_i, .conv_done_i,
		.conv_ch_i, .out_of_range_i, .cfg_change_i, .conv_start_o, .seq_pos_o, .seq_inj_o,
		.pair_mode_o, .restart_o, .int_ch_en_o, .irq_o);

	// ***************************************
	// Shared tasks
	// ***************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1 rv = rdata_o;
	endtask
	// One-cycle pulse: 0 trigger, 1 done, 2 data read, 3 setup change, 4 injected trigger
	task automatic fire(input int w, input logic oor);
		@(posedge core_clk_i);
		case (w)
			0: reg_trig_i <= 1'b1;
			1: conv_done_i <= 1'b1;
			2: data_read_i <= 1'b1;
			4: inj_trig_i <= 1'b1;
			default: cfg_change_i <= 1'b1;
		endcase
		out_of_range_i <= oor;
		@(posedge core_clk_i);
		{reg_trig_i, inj_trig_i, conv_done_i, data_read_i, cfg_change_i} <= 5'h00;
		#1;
	endtask

	// ***************************************
	// Scenarios
	// ***************************************
	task automatic t_regs;
		rd(`CCO_OFFSET);
		chk(rv, `CCO_RESET);
		wr(`CCO_OFFSET, 32'hFFFF_FFFF);
		rd(`CCO_OFFSET);
		chk(rv, `CCO_WMASK);
		wr(8'h10, 32'h0000_0000);
		rd(`CCO_OFFSET);
		chk(rv, `CCO_WMASK);
		rd(8'h10);
		chk(rv, 32'h0000_0000);
		chk(int_ch_en_o, 32'h0000_0001);
	endtask
	// Every pair code, then a setup change under it
	task automatic t_modes;
		for (int m = 0; m < 10; m++) begin
			wr(`CCO_OFFSET, 32'(m) << 16);
			cyc(2);
			chk(pair_mode_o, 32'(m));
			fire(3, 1'b0);
			chk(restart_o, 32'(m != 0));
		end
		wr(`CCO_OFFSET, 32'h0000_0000);
		fire(3, 1'b0);
		chk(restart_o, 32'h0000_0000);
		wr(`CCO_OFFSET, 32'h0009_0000);
	endtask
	task automatic t_conv;
		wr(`CCO_OFFSET, 32'h0000_0020);
		fire(0, 1'b0);
		cyc(1);
		chk(conv_start_o, 32'h0000_0001);
		fire(1, 1'b0);
		cyc(3);
		chk(irq_o, 32'h0000_0001);
		rd(8'h00);
		chk(rv[1], 32'h0000_0001);
		fire(2, 1'b0);
		cyc(2);
		chk(irq_o, 32'h0000_0000);
		rd(8'h00);
		chk(rv[1], 32'h0000_0000);
	endtask
	// Crossing ignored while regular watch is off, flagged once it is on
	task automatic t_watch;
		wr(`CCO_OFFSET, 32'h0000_0040);
		fire(0, 1'b0);
		cyc(2);
		fire(1, 1'b1);
		cyc(3);
		chk(irq_o, 32'h0000_0000);
		wr(`CCO_OFFSET, 32'h0080_0040);
		fire(0, 1'b0);
		cyc(2);
		fire(1, 1'b1);
		cyc(3);
		chk(irq_o, 32'h0000_0001);
		wr(8'h00, 32'h0000_0000);
		cyc(2);
		chk(irq_o, 32'h0000_0000);
	endtask

	// Two-channel scan flags done only after the second channel
	task automatic t_scan;
		wr(8'h00, 32'h0000_0000);
		wr(`CCO_OFFSET, 32'h0000_0120);
		@(posedge core_clk_i);
		reg_len_i <= 4'h1;
		fire(0, 1'b0);
		fire(1, 1'b0);
		rd(8'h00);
		chk(rv[1], 32'h0000_0000);
		fire(1, 1'b0);
		rd(8'h00);
		chk(rv[1], 32'h0000_0001);
		chk(irq_o, 32'h0000_0001);
	endtask
	// Bursts of two in a four-channel scan; position kept between bursts
	task automatic t_burst;
		wr(`CCO_OFFSET, 32'h0000_2900);
		@(posedge core_clk_i);
		reg_len_i <= 4'h3;
		fire(0, 1'b0);
		fire(1, 1'b0);
		fire(1, 1'b0);
		fire(1, 1'b0);
		cyc(1);
		chk(seq_pos_o, 32'h0000_0002);
		fire(0, 1'b0);
		fire(1, 1'b0);
		cyc(1);
		chk(seq_pos_o, 32'h0000_0003);
		fire(1, 1'b0);
		cyc(1);
		chk(seq_pos_o, 32'h0000_0000);
	endtask
	// Injected group: chained after regular, watched, and in bursts
	task automatic t_inj;
		wr(8'h00, 32'h0000_0000);
		wr(`CCO_OFFSET, 32'h0000_0480);
		fire(0, 1'b0);
		fire(1, 1'b0);
		cyc(1);
		chk(seq_inj_o, 32'h0000_0001);
		fire(1, 1'b0);
		cyc(1);
		chk(irq_o, 32'h0000_0001);
		rd(8'h00);
		chk(rv[2], 32'h0000_0001);
		wr(8'h00, 32'h0000_0000);
		wr(`CCO_OFFSET, 32'h0040_0040);
		fire(4, 1'b0);
		fire(1, 1'b1);
		cyc(2);
		chk(irq_o, 32'h0000_0001);
		wr(8'h00, 32'h0000_0000);
		wr(`CCO_OFFSET, 32'h0000_1100);
		@(posedge core_clk_i);
		inj_len_i <= 2'h1;
		fire(4, 1'b0);
		fire(1, 1'b0);
		cyc(1);
		chk(seq_inj_o, 32'h0000_0000);
	endtask
	// Enabled watch interrupt cuts a scan short; single-channel watch skips others
	task automatic t_abort;
		wr(8'h00, 32'h0000_0000);
		wr(`CCO_OFFSET, 32'h0080_0140);
		fire(0, 1'b0);
		fire(1, 1'b1);
		rd(8'h00);
		chk(rv[1], 32'h0000_0001);
		wr(8'h00, 32'h0000_0000);
		wr(`CCO_OFFSET, 32'h0080_0251);
		fire(0, 1'b0);
		fire(1, 1'b1);
		rd(8'h00);
		chk(rv[0], 32'h0000_0000);
	endtask

	task automatic end_of_test;
		if (num_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ***************************************
	// Clock, sequence and watchdog
	// ***************************************
	initial begin
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	initial begin
		repeat (3) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		t_regs();
		t_modes();
		t_conv();
		t_watch();
		t_scan();
		t_burst();
		t_inj();
		t_abort();
		end_of_test();
	end
	// Tests need about a microsecond; a hang is cut off far beyond that
	initial begin
		#20000;
		num_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
